// >>> src/link_sampler.sv
// Purpose: Synchroniser with edge finder for the serial pins
// Assumes: Inputs arrive from outside the ref_clk domain
// Notes:   Resets to all ones, the idle level of the pins, so no false edge

`timescale 1ns/1ps
`default_nettype none

module link_sampler #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// Asynchronous inputs
	input  wire logic [WIDTH-1:0] async_in,
	// Synchronised levels and edges
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ----------------------------------------------------------------
	// Two-flop synchroniser and one delay for edges
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage1 <= '1;
			stage2 <= '1;
			stage3 <= '1;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise  = stage2 & ~stage3;
	assign fall  = ~stage2 & stage3;
endmodule

`default_nettype wire

// >>> src/serial_port.sv
// Purpose: Serial register port and ready flag of a converter
// Assumes: sclk idles high; host samples dout on sclk rising edges
// Notes:   Converter datapath is outside; it reports results and calibration

package serial_port_pkg;
	// ----------------------------------------------------------------
	// Word widths
	// ----------------------------------------------------------------
	localparam int COMM_BITS  = 8;
	localparam int DATA_BITS  = 24;
	localparam int CAL_BITS   = 24;
	localparam int CTRL_BITS  = 8;
	localparam int SHIFT_BITS = 24;
	localparam int CNT_BITS   = 5;

	// ----------------------------------------------------------------
	// Communications byte fields
	// ----------------------------------------------------------------
	localparam int COMM_READ_POS = 6;
	localparam int COMM_SEL_LSB  = 0;
	localparam int COMM_SEL_BITS = 4;

	// ----------------------------------------------------------------
	// Register selection codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_CTRL = 4'h1;
	localparam logic [3:0] SEL_DATA = 4'h2;
	localparam logic [3:0] SEL_CAL  = 4'h3;

	// ----------------------------------------------------------------
	// Control register mode field and reset values
	// ----------------------------------------------------------------
	localparam int MODE_LSB  = 0;
	localparam int MODE_BITS = 3;
	localparam logic [3:0]  MODE_IDLE  = 4'h0;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [23:0] CAL_RESET  = 24'h000000;
	localparam logic [23:0] DATA_RESET = 24'h000000;

	// ----------------------------------------------------------------
	// Sampling
	// ----------------------------------------------------------------
	localparam int SYNC_WIDTH = 3;
	localparam int SYNC_SCLK  = 0;
	localparam int SYNC_CS    = 1;
	localparam int SYNC_DIN   = 2;
endpackage

`timescale 1ns/1ps
`default_nettype none

module serial_port (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Serial pins
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe,
	output logic             rdy_n,
	// Converter side
	input  wire logic        result_valid,
	input  wire logic [23:0] result_data,
	input  wire logic        pre_update,
	input  wire logic        cal_done,
	output logic      [23:0] cal_word,
	output logic      [7:0]  ctrl_word,
	output logic             mode_start,
	output logic             data_read
);
	typedef enum logic [0:0] {ST_COMM, ST_DATA} phase_t;

	logic [2:0]  pin_level;
	logic [2:0]  pin_rise;
	logic [2:0]  pin_fall;
	logic        sel_n;
	logic        clk_rise;
	logic        clk_fall;
	logic        bit_in;
	phase_t      phase;
	logic [4:0]  bit_cnt;
	logic [23:0] in_shift;
	logic [23:0] out_shift;
	logic        is_read;
	logic [3:0]  sel;
	logic [23:0] data_reg;
	logic        data_unread;
	logic        cal_hold;
	logic [7:0]  next_comm;
	logic [23:0] next_word;
	logic        last_bit;
	logic        word_done;
	logic        mode_write;
	logic        comm_last;
	logic        comm_read;
	logic [3:0]  comm_sel;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	link_sampler #(
		.WIDTH (serial_port_pkg::SYNC_WIDTH)
	) u_sampler (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in ({din, cs_n, sclk}),
		.level    (pin_level),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	assign sel_n    = pin_level[serial_port_pkg::SYNC_CS];
	assign clk_rise = pin_rise[serial_port_pkg::SYNC_SCLK] & ~sel_n;
	assign clk_fall = pin_fall[serial_port_pkg::SYNC_SCLK] & ~sel_n;
	assign bit_in   = pin_level[serial_port_pkg::SYNC_DIN];

	// Width of the data phase for a register selection
	function automatic logic [4:0] word_len(input logic [3:0] s);
		if (s == serial_port_pkg::SEL_DATA) begin
			word_len = 5'(serial_port_pkg::DATA_BITS);
		end else if (s == serial_port_pkg::SEL_CAL) begin
			word_len = 5'(serial_port_pkg::CAL_BITS);
		end else begin
			word_len = 5'(serial_port_pkg::CTRL_BITS);
		end
	endfunction

	// Read value, left-justified in the output shift register
	function automatic logic [23:0] read_value(input logic [3:0] s,
		input logic [23:0] d, input logic [23:0] c, input logic [7:0] k);
		if (s == serial_port_pkg::SEL_DATA) begin
			read_value = d;
		end else if (s == serial_port_pkg::SEL_CAL) begin
			read_value = c;
		end else if (s == serial_port_pkg::SEL_CTRL) begin
			read_value = {k, 16'h0000};
		end else begin
			read_value = 24'h000000;
		end
	endfunction

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	assign next_comm = {in_shift[6:0], bit_in};
	assign next_word = {in_shift[22:0], bit_in};
	assign comm_last = clk_rise && (phase == ST_COMM) && last_bit;
	assign comm_read = next_comm[serial_port_pkg::COMM_READ_POS];
	assign comm_sel  = next_comm[serial_port_pkg::COMM_SEL_LSB
		+: serial_port_pkg::COMM_SEL_BITS];
	assign last_bit  = (phase == ST_COMM)
		? (bit_cnt == 5'(serial_port_pkg::COMM_BITS - 1))
		: (bit_cnt == word_len(sel) - 5'h01);
	assign word_done  = clk_rise && (phase == ST_DATA) && last_bit;
	assign mode_write = word_done && !is_read
		&& (sel == serial_port_pkg::SEL_CTRL)
		&& (next_word[serial_port_pkg::MODE_LSB +: serial_port_pkg::MODE_BITS]
			!= serial_port_pkg::MODE_IDLE[2:0]);

	// ----------------------------------------------------------------
	// Phase and bit counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase   <= ST_COMM;
			bit_cnt <= 5'h00;
		end else if (sel_n) begin
			phase   <= ST_COMM;
			bit_cnt <= 5'h00;
		end else if (clk_rise) begin
			if (last_bit) begin
				bit_cnt <= 5'h00;
				phase   <= (phase == ST_COMM) ? ST_DATA : ST_COMM;
			end else begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Input shift register and communications byte
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			in_shift <= 24'h000000;
			is_read  <= 1'b0;
			sel      <= 4'h0;
		end else if (sel_n) begin
			in_shift <= 24'h000000;
		end else if (clk_rise) begin
			in_shift <= next_word;
			if (comm_last) begin
				is_read  <= comm_read;
				sel      <= comm_sel;
				in_shift <= 24'h000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cal_word  <= serial_port_pkg::CAL_RESET;
			ctrl_word <= serial_port_pkg::CTRL_RESET;
		end else if (word_done && !is_read) begin
			if (sel == serial_port_pkg::SEL_CAL) begin
				cal_word <= next_word;
			end else if (sel == serial_port_pkg::SEL_CTRL) begin
				ctrl_word <= next_word[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output shift register and serial output
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			out_shift <= 24'h000000;
			dout      <= 1'b0;
		end else if (sel_n) begin
			out_shift <= 24'h000000;
			dout      <= 1'b0;
		end else if (comm_last) begin
			if (comm_read) begin
				out_shift <= read_value(comm_sel, data_reg,
					cal_word, ctrl_word);
			end else begin
				out_shift <= 24'h000000;
			end
		end else if (clk_fall) begin
			dout      <= out_shift[23];
			out_shift <= {out_shift[22:0], 1'b0};
		end
	end

	assign dout_oe = ~sel_n;

	// ----------------------------------------------------------------
	// Data register and ready flag
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			data_reg <= serial_port_pkg::DATA_RESET;
		end else if (result_valid) begin
			data_reg <= result_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			data_unread <= 1'b0;
		end else if (result_valid) begin
			data_unread <= 1'b1;
		end else if (data_read || pre_update) begin
			data_unread <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cal_hold <= 1'b0;
		end else if (cal_done) begin
			cal_hold <= 1'b1;
		end else if (mode_write) begin
			cal_hold <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_start <= 1'b0;
			data_read  <= 1'b0;
		end else begin
			mode_start <= mode_write;
			data_read  <= word_done && is_read
				&& (sel == serial_port_pkg::SEL_DATA);
		end
	end

	assign rdy_n = ~(data_unread | cal_hold);
endmodule

`default_nettype wire

// >>> testbench/host_model.sv
// Purpose: Host side of the serial link
// Assumes: Tasks are called from the bench
// Notes:   sclk stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        ref_clk,
	input  wire logic        sdo,
	output logic             sclk,
	output logic             cs_n,
	output logic             din,
	output logic [23:0]      rx
);
	event got;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rx = 24'h0;
	end
	// Shifts n bits MSB first, 320 ns per bit plus gap
	task automatic xfer(input logic [23:0] tx, input int n, input int gap,
		input bit sel, input bit note);
		@(negedge ref_clk) cs_n = !sel;
		rx = 24'h0;
		repeat (3) @(negedge ref_clk);
		for (int i = n - 1; i >= 0; i--) begin
			repeat (gap) @(negedge ref_clk);
			sclk = 1'b0;
			din = tx[i];
			repeat (5) @(negedge ref_clk);
			sclk = 1'b1;
			rx = {rx[22:0], sdo};
			repeat (3) @(negedge ref_clk);
		end
		if (note) -> got;
	endtask
	task automatic release_bus;
		@(negedge ref_clk) cs_n = 1'b1;
		din = ~din;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule
`default_nettype wire

// >>> testbench/serial_port_asserts.sv
// Purpose: Port checker for serial_port
// Assumes: Sees the top module's ports only
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module serial_port_asserts (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic       cs_n,
	input wire logic       dout,
	input wire logic       dout_oe,
	input wire logic       rdy_n,
	input wire logic       result_valid,
	input wire logic       pre_update,
	input wire logic       cal_done,
	input wire logic [7:0] ctrl_word,
	input wire logic       mode_start,
	input wire logic       data_read
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic clr;
	logic set;
	logic hold;
	assign clr = data_read | pre_update | mode_start;
	assign set = result_valid | cal_done;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) hold <= 1'b0;
		else if (cal_done) hold <= 1'b1;
		else if (mode_start) hold <= 1'b0;
	end
	property p_oe_off; cs_n [*3] |-> !dout_oe; endproperty
	property p_idle; cs_n [*5] |-> !dout; endproperty
	property p_oe_on; !cs_n [*3] |-> dout_oe; endproperty
	property p_read; data_read && !hold |-> ##[0:2] rdy_n; endproperty
	property p_rise; $rose(rdy_n) |-> clr || $past(clr) || $past(clr, 2);
	endproperty
	property p_fall; $fell(rdy_n) |-> $past(set) || $past(set, 2);
	endproperty
	property p_result; result_valid |-> ##[1:2] !rdy_n; endproperty
	property p_cal; hold && $past(hold) && !mode_start |-> !rdy_n;
	endproperty
	property p_mode; mode_start |-> ctrl_word[2:0] != 3'h0 ##1 !mode_start;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("dout driven while deselected");
	a_idle: assert property (p_idle)
		else $error("dout not cleared while deselected");
	a_oe_on: assert property (p_oe_on)
		else $error("dout not driven while selected");
	a_read: assert property (p_read)
		else $error("ready not raised after data read");
	a_rise: assert property (p_rise)
		else $error("ready raised without cause");
	a_fall: assert property (p_fall)
		else $error("ready lowered without cause");
	a_result: assert property (p_result)
		else $error("ready not lowered by result");
	a_cal: assert property (p_cal)
		else $error("ready left calibration hold");
	a_mode: assert property (p_mode)
		else $error("mode start without mode bits");
	c_read: cover property (data_read);
	c_cal: cover property (cal_done ##[1:900] mode_start);
	c_pre: cover property (pre_update ##1 rdy_n);
endmodule
bind serial_port serial_port_asserts serial_port_asserts_inst (
	.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .dout(dout),
	.dout_oe(dout_oe), .rdy_n(rdy_n), .result_valid(result_valid),
	.pre_update(pre_update), .cal_done(cal_done), .ctrl_word(ctrl_word),
	.mode_start(mode_start), .data_read(data_read));
`default_nettype wire

// >>> testbench/serial_port_tb.sv
// Purpose: Self-checking bench for serial_port
// Assumes: Host model drives the link
// Notes:   Read results are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
	logic ref_clk, rstn, sdo, result_valid, pre_update, cal_done;
	logic sclk, cs_n, din, dout, dout_oe, rdy_n, mode_start, data_read;
	logic sdo_last = 1'b0;
	logic [23:0] result_data, cal_word, rx, v;
	logic [7:0] ctrl_word;
	logic [23:0] expq[$];
	int num_errors, comparisons, seed;
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (dout_oe) sdo_last <= dout;
	assign sdo = dout_oe ? dout : ~sdo_last;
	serial_port serial_port_inst (.ref_clk(ref_clk), .rstn(rstn),
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.rdy_n(rdy_n), .result_valid(result_valid), .result_data(result_data),
		.pre_update(pre_update), .cal_done(cal_done), .cal_word(cal_word),
		.ctrl_word(ctrl_word), .mode_start(mode_start), .data_read(data_read));
	host_model host_model_inst (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk),
		.cs_n(cs_n), .din(din), .rx(rx));
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(host_model_inst.got)
		check(rx, expq.size() ? expq.pop_front() : 'x);
	task automatic wr(input logic [3:0] s, input logic [23:0] d, input int n,
		input int gap);
		host_model_inst.xfer({20'h0, s}, 8, 0, 1, 0);
		host_model_inst.xfer(d, n, gap, 1, 0);
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] s, input logic [23:0] e, input int n);
		expq.push_back(e);
		host_model_inst.xfer({16'h0, 4'h4, s}, 8, 0, 1, 0);
		host_model_inst.xfer(24'h0, n, 0, 1, 1);
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic conv(input logic r, input logic p, input logic c);
		@(negedge ref_clk) {result_valid, pre_update, cal_done} = {r, p, c};
		@(negedge ref_clk) {result_valid, pre_update, cal_done} = 3'h0;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		$display("CHECK FAILED %0t timeout", $time);
		tally_and_finish;
	end
	initial begin
		seed = 32'hFA80;
		{rstn, result_valid, pre_update, cal_done} = 4'h0;
		result_data = 24'h0;
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(24'(rdy_n), 24'h1);
		check(24'(ctrl_word), 24'(serial_port_pkg::CTRL_RESET));
		check(cal_word, serial_port_pkg::CAL_RESET);
		wr(serial_port_pkg::SEL_CTRL, 24'h5, 8, 0);
		check(24'(ctrl_word), 24'h5);
		v = 24'($random(seed));
		wr(serial_port_pkg::SEL_CAL, v, 24, 7);
		check(cal_word, v);
		rd(serial_port_pkg::SEL_CAL, v, 24);
		rd(serial_port_pkg::SEL_CTRL, 24'h5, 8);
		rd(4'hF, 24'h0, 8);
		result_data = 24'($random(seed));
		conv(1, 0, 0);
		check(24'(rdy_n), 24'h0);
		rd(serial_port_pkg::SEL_DATA, result_data, 24);
		check(24'(rdy_n), 24'h1);
		result_data = 24'($random(seed));
		conv(1, 0, 0);
		conv(0, 1, 0);
		check(24'(rdy_n), 24'h1);
		conv(0, 0, 1);
		check(24'(rdy_n), 24'h0);
		rd(serial_port_pkg::SEL_DATA, result_data, 24);
		check(24'(rdy_n), 24'h0);
		wr(serial_port_pkg::SEL_CTRL, 24'h2, 8, 0);
		check(24'(rdy_n), 24'h1);
		host_model_inst.xfer(24'h1, 8, 0, 0, 0);
		host_model_inst.xfer(24'h7, 8, 0, 0, 0);
		check(24'(ctrl_word), 24'h2);
		host_model_inst.xfer(24'h7, 3, 0, 1, 0);
		host_model_inst.release_bus();
		wr(serial_port_pkg::SEL_CTRL, 24'h6, 8, 0);
		check(24'(ctrl_word), 24'h6);
		host_model_inst.xfer(24'h1, 8, 0, 1, 0);
		@(negedge ref_clk) rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(24'(rdy_n), 24'h1);
		check(24'(ctrl_word), 24'(serial_port_pkg::CTRL_RESET));
		check(cal_word, serial_port_pkg::CAL_RESET);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		wr(serial_port_pkg::SEL_CTRL, 24'h3, 8, 0);
		check(24'(ctrl_word), 24'h3);
		repeat (10) @(negedge ref_clk);
		tally_and_finish;
	end
endmodule
`default_nettype wire
